/* logic/pta_pkg.sv */
// Summary of operation
// - clock source select picks auxiliary PLL tick when set, primary VCO tick when clear
// - global_soft_trigger fires selecting pairs on its rise; software must clear it
// - footnoted fields change only while converter_power_on is 0
// - one converter, one conversion at a time, at least half a microsecond each
// - simultaneous requests convert in turn, lowest input number first
// - three inputs held at once: two dedicated holds plus the shared hold
// - each consecutive input pair selects its own trigger among sixteen sources
// - each pair is triggered independently of the others; only pair 0 loads dedicated holds at its trigger
// - eight external plus two internal inputs, each with its own ten-bit result
// - two highest inputs are the external and internal reference voltages
//
// Purpose: constants and types of the pair-triggered converter control block
// Assumes: register offsets are byte addresses on a 32-bit AXI4-Lite bus
// Notes:   all counts derive from a 100 MHz aclk
package pta_pkg;

   localparam int          NUM_INPUTS    = 10;
   localparam int          NUM_PAIRS     = 5;
   localparam int          NUM_EXT       = 8;
   localparam int          NUM_TRIG      = 14;
   localparam int          RES_W         = 10;

   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_TRIG     = 8'h10;
   localparam logic [7:0]  ADDR_RESULT   = 8'h40;

   localparam int          B_ON          = 15;
   localparam int          B_SIDL        = 13;
   localparam int          B_CLK_SRC     = 12;
   localparam int          B_GSW         = 10;
   localparam int          B_RESULT_FORMAT        = 8;
   localparam int          B_EARLY       = 7;
   localparam int          B_ORDER       = 6;
   localparam int          B_SEQ         = 5;
   localparam int          B_ASYNC       = 4;
   localparam int          B_DIV         = 0;
   localparam int          B_BUSY        = 16;
   localparam int          B_RUN         = 17;

   localparam logic [2:0]  DIV_RESET     = 3'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [3:0]  SRC_SOFT      = 4'h1;

   localparam int          CLK_PERIOD_NS = 10;
   localparam int          CONV_TIME_NS  = 500;
   localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic       on;
      logic       sidl;
      logic       clk_src;
      logic       gsw;
      logic       result_format;
      logic       early;
      logic       order;
      logic       seq;
      logic       async_s;
      logic [2:0] div;
   } pta_ctl_t;

   localparam pta_ctl_t CTL_RESET = '{on: 1'b0, sidl: 1'b0, clk_src: 1'b0, gsw: 1'b0,
                                      result_format: 1'b0, early: 1'b0, order: 1'b0, seq: 1'b0,
                                      async_s: 1'b0, div: DIV_RESET};

endpackage : pta_pkg

/* logic/pta_sar_core.sv */
// Purpose: one successive-approximation engine, one conversion at a time
// Assumes: tick is a one-cycle enable from the selected converter clock
// Notes:   the cycle floor caps throughput whatever the tick rate
`timescale 1ns/1ns
`default_nettype none
module pta_sar_core
   import pta_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             clear,
   input  wire logic             en,
   input  wire logic             tick,
   input  wire logic             start,
   input  wire logic [RES_W-1:0] sample,
   output logic                  busy,
   output logic                  done,
   output logic [RES_W-1:0]      result
);

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONV = 2'b10} pta_sar_st_t;

   pta_sar_st_t      state;
   logic [RES_W-1:0] held;
   logic [RES_W-1:0] approx;
   logic [RES_W-1:0] probe;
   logic [6:0]       cycles;

   wire [RES_W-1:0]  trial     = approx | probe;
   wire              resolved  = (probe == '0);
   wire              floor_met = (cycles >= 7'(CONV_CYCLES - 1));

   assign busy = (state == ST_CONV);

   always_ff @(posedge aclk) begin
      done <= 1'b0;
      if (!aresetn || clear) begin
         state  <= ST_IDLE;
         held   <= '0;
         approx <= '0;
         probe  <= '0;
         cycles <= '0;
         result <= '0;
      end else if (en) begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state  <= ST_CONV;
                  held   <= sample;
                  approx <= '0;
                  probe  <= {1'b1, {(RES_W-1){1'b0}}};
                  cycles <= '0;
               end
            end
            ST_CONV: begin
               if (!floor_met) cycles <= cycles + 7'd1;
               if (tick && !resolved) begin
                  if (trial <= held) approx <= trial;
                  probe <= probe >> 1;
               end
               if (resolved && floor_met) begin
                  state  <= ST_IDLE;
                  result <= approx;
                  done   <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule : pta_sar_core
`default_nettype wire

/* logic/pta_pair_trigger_adc.sv */
// Purpose: pair-triggered converter control with an AXI4-Lite register slave
// Assumes: triggers, idle, clock ticks and analog codes come from aclk logic
// Notes:   results are kept per input; a new one overwrites the old
`timescale 1ns/1ns
`default_nettype none
module pta_pair_trigger_adc
   import pta_pkg::*;
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic [NUM_TRIG-1:0]        trigger_in,
   input  wire logic                       device_idle,
   input  wire logic                       aux_pll_tick,
   input  wire logic                       primary_vco_tick,
   input  wire logic [NUM_EXT-1:0][RES_W-1:0] ext_analog,
   input  wire logic [RES_W-1:0]           external_reference_voltage,
   input  wire logic [RES_W-1:0]           internal_reference_voltage,
   output logic                            converter_running,
   output logic                            converter_tick,
   output logic                            conversion_done,
   output logic [3:0]                      done_index
);

   // lowest set bit wins, so equal-time requests go in input order
   function automatic logic [3:0] lowest_index(input logic [NUM_INPUTS-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
         if (v[i]) idx = 4'(i);
      end
      return idx;
   endfunction : lowest_index

   function automatic logic [31:0] ctl_word(input pta_ctl_t c);
      logic [31:0] w;
      w              = 32'h0000_0000;
      w[B_ON]        = c.on;
      w[B_SIDL]      = c.sidl;
      w[B_CLK_SRC]   = c.clk_src;
      w[B_GSW]       = c.gsw;
      w[B_RESULT_FORMAT]      = c.result_format;
      w[B_EARLY]     = c.early;
      w[B_ORDER]     = c.order;
      w[B_SEQ]       = c.seq;
      w[B_ASYNC]     = c.async_s;
      w[B_DIV +: 3]  = c.div;
      return w;
   endfunction : ctl_word

   pta_ctl_t                   ctl;
   pta_ctl_t                   next_ctl;
   logic [4:0]                 trig_src [NUM_PAIRS];
   logic [RES_W-1:0]           results  [NUM_INPUTS];
   logic [NUM_INPUTS-1:0]      pending;
   logic [NUM_INPUTS-1:0]      next_pending;
   logic [RES_W-1:0]           hold0;
   logic [RES_W-1:0]           hold1;
   logic                       gsw_q;
   logic [3:0]                 cur_idx;

   logic                       aw_full;
   logic [7:0]                 aw_addr_q;
   logic                       w_full;
   logic [31:0]                w_data_q;
   logic [3:0]                 w_strb_q;
   logic [31:0]                rd_word;
   logic                       rd_hit;

   logic                       core_busy;
   logic                       core_done;
   logic [RES_W-1:0]           core_result;

   // analog map: externals first, then the two reference monitors
   wire  [RES_W-1:0]           ain [NUM_INPUTS];
   for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
      assign ain[i] = ext_analog[i];
   end
   assign ain[NUM_INPUTS-2] = external_reference_voltage;
   assign ain[NUM_INPUTS-1] = internal_reference_voltage;

   // ---- run state and clock selection
   wire run      = ctl.on && !(ctl.sidl && device_idle);
   wire sel_tick = ctl.clk_src ? aux_pll_tick : primary_vco_tick;
   wire gsw_rise = ctl.gsw && !gsw_q;

   // ---- trigger sources: 0 none, 1 global software, 2..15 trigger_in
   wire [15:0] src_vec = {trigger_in, gsw_rise, 1'b0};
   wire [NUM_PAIRS-1:0] pair_fire;
   wire [NUM_INPUTS-1:0] set_pend;
   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
      assign pair_fire[p] = !trig_src[p][4] && src_vec[trig_src[p][3:0]];
      assign set_pend[2*p]   = run && pair_fire[p];
      assign set_pend[2*p+1] = run && pair_fire[p];
   end

   // ---- arbitration
   wire [3:0] sel_idx = lowest_index(pending);
   wire start = run && !core_busy && (pending != '0);
   wire [NUM_INPUTS-1:0] clr_pend = start ? NUM_INPUTS'(1) << sel_idx : '0;
   wire [RES_W-1:0] sample = (sel_idx == 4'h0) ? hold0 :
                             (sel_idx == 4'h1) ? hold1 : ain[sel_idx];

   always_comb begin
      // an idle halt keeps waiting requests, only power-off drops them
      next_pending = ctl.on ? pending : '0;
      if (run) next_pending = (pending & ~clr_pend) | set_pend;
   end

   // ---- register write path
   assign s_axi_awready = !aw_full;
   assign s_axi_wready  = !w_full;
   wire do_write = aw_full && w_full && !s_axi_bvalid;
   wire wr_ctl   = do_write && (aw_addr_q == ADDR_CTRL);
   wire [NUM_PAIRS-1:0] wr_trig;
   wire [NUM_PAIRS-1:0] trig_hit;
   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_wdec
      assign trig_hit[p] = (aw_addr_q == ADDR_TRIG + 8'(4 * p));
      assign wr_trig[p]  = do_write && trig_hit[p] && w_strb_q[0];
   end
   wire wr_hit = (aw_addr_q == ADDR_CTRL) || (trig_hit != '0);

   wire [31:0] cur_word = ctl_word(ctl);
   wire [15:0] merged = {w_strb_q[1] ? w_data_q[15:8] : cur_word[15:8],
                         w_strb_q[0] ? w_data_q[7:0]  : cur_word[7:0]};

   always_comb begin
      next_ctl = ctl;
      if (wr_ctl) begin
         next_ctl.on   = merged[B_ON];
         next_ctl.sidl = merged[B_SIDL];
         next_ctl.gsw  = merged[B_GSW];
         if (!ctl.on) begin
            next_ctl.clk_src = merged[B_CLK_SRC];
            next_ctl.result_format    = merged[B_RESULT_FORMAT];
            next_ctl.early   = merged[B_EARLY];
            next_ctl.order   = merged[B_ORDER];
            next_ctl.seq     = merged[B_SEQ];
            next_ctl.async_s = merged[B_ASYNC];
            next_ctl.div     = merged[B_DIV +: 3];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end else if (s_axi_awvalid && !aw_full) begin
         aw_full   <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full   <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (do_write) begin
         w_full <= 1'b0;
      end else if (s_axi_wvalid && !w_full) begin
         w_full   <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl   <= CTL_RESET;
         gsw_q <= 1'b0;
      end else begin
         ctl   <= next_ctl;
         gsw_q <= ctl.gsw;
      end
   end

   always_ff @(posedge aclk) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (!aresetn) trig_src[p] <= 5'h00;
         else if (wr_trig[p]) trig_src[p] <= w_data_q[4:0];
      end
   end

   // ---- read path; unused bit positions fall out as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b0;
      if (s_axi_araddr == ADDR_CTRL) begin
         rd_word = cur_word;
         rd_hit  = 1'b1;
      end
      if (s_axi_araddr == ADDR_STATUS) begin
         rd_word[NUM_INPUTS-1:0] = pending;
         rd_word[B_BUSY]         = core_busy;
         rd_word[B_RUN]          = run;
         rd_hit                  = 1'b1;
      end
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (s_axi_araddr == ADDR_TRIG + 8'(4 * p)) begin
            rd_word[4:0] = trig_src[p];
            rd_hit       = 1'b1;
         end
      end
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (s_axi_araddr == ADDR_RESULT + 8'(4 * i)) begin
            // fractional result_format left-justifies the code in 16 bits
            rd_word = ctl.result_format ? {16'h0000, results[i], 6'h00}
                               : {22'h000000, results[i]};
            rd_hit  = 1'b1;
         end
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---- requests and dedicated holds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= '0;
         hold0   <= '0;
         hold1   <= '0;
         cur_idx <= 4'h0;
      end else begin
         pending <= next_pending;
         if (set_pend[0]) begin
            hold0 <= ain[0];
            hold1 <= ain[1];
         end
         if (start) cur_idx <= sel_idx;
      end
   end

   // ---- converter engine; a halt freezes it, power-off aborts it
   pta_sar_core u_core (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (!ctl.on),
      .en      (run),
      .tick    (sel_tick),
      .start   (start),
      .sample  (sample),
      .busy    (core_busy),
      .done    (core_done),
      .result  (core_result)
   );

   always_ff @(posedge aclk) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (!aresetn) results[i] <= '0;
         else if (core_done && cur_idx == 4'(i)) results[i] <= core_result;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_running <= 1'b0;
         converter_tick    <= 1'b0;
         conversion_done   <= 1'b0;
         done_index        <= 4'h0;
      end else begin
         converter_running <= run;
         converter_tick    <= run && sel_tick;
         conversion_done   <= core_done;
         if (core_done) done_index <= cur_idx;
      end
   end

endmodule : pta_pair_trigger_adc
`default_nettype wire

/* tb/pta_pair_trigger_adc_assertions.sv */
// Purpose: port-level checks of the pair-triggered converter control
// Assumes: control state is rebuilt from the AXI4-Lite writes seen at the ports
// Notes:   a write lands at the edge that raises bvalid
`timescale 1ns/1ns
`default_nettype none
module pta_pair_trigger_adc_assertions
   import pta_pkg::*;
(
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic [7:0]       s_axi_awaddr,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic [31:0]      s_axi_wdata,
   input wire logic [3:0]       s_axi_wstrb,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic [7:0]       s_axi_araddr,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   input wire logic             s_axi_rvalid,
   input wire logic             device_idle,
   input wire logic             aux_pll_tick,
   input wire logic             primary_vco_tick,
   input wire logic             converter_running,
   input wire logic             converter_tick,
   input wire logic             conversion_done,
   input wire logic [3:0]       done_index
);
   logic [7:0]  wa;
   logic [7:0]  ra;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic        bq, on, sidl, slow, seen;
   logic [5:0]  gap;
   wire rise   = s_axi_bvalid && !bq;
   wire hit    = rise && wa == ADDR_CTRL && ws[1];
   wire c_on   = hit ? wd[B_ON] : on;
   wire c_sidl = hit ? wd[B_SIDL] : sidl;
   // clock source only moves while the converter was off before the write
   wire c_slow = (hit && !on) ? wd[B_CLK_SRC] : slow;
   wire run_c  = c_on && !(c_sidl && device_idle);
   wire sel_t  = c_slow ? aux_pll_tick : primary_vco_tick;
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {bq, on, sidl, slow, seen} <= 5'h0;
         gap <= 6'h0;
      end else begin
         {bq, on, sidl, slow} <= {s_axi_bvalid, c_on, c_sidl, c_slow};
         seen <= seen | conversion_done;
         gap <= conversion_done ? 6'h0 : (gap == 6'h3f ? gap : gap + 6'h1);
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   run_state_a: assert property (
      $past(aresetn) |-> converter_running == $past(run_c)) else $error("running flag wrong");
   tick_select_a: assert property (
      $past(aresetn) |-> converter_tick == $past(run_c && sel_t)) else $error("tick wrong");
   conv_gap_a: assert property (
      conversion_done && seen |-> gap >= CONV_CYCLES - 1) else $error("conversions too close");
   done_running_a: assert property (
      conversion_done |-> converter_running) else $error("done while stopped");
   done_index_a: assert property (
      conversion_done |-> done_index < NUM_INPUTS) else $error("done index out of range");
   ctl_zero_a: assert property (
      s_axi_rvalid && ra == ADDR_CTRL |-> (s_axi_rdata & 32'hffff4a08) == 32'h0)
      else $error("unused control bits not zero");
   unmapped_rd_a: assert property (
      s_axi_rvalid && ra == 8'h08 |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   rd_latency_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : pta_pair_trigger_adc_assertions
bind pta_pair_trigger_adc pta_pair_trigger_adc_assertions u_chk (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .device_idle, .aux_pll_tick, .primary_vco_tick,
   .converter_running, .converter_tick, .conversion_done, .done_index);
`default_nettype wire

/* tb/pta_far_side.sv */
// Purpose: trigger sources, converter clock ticks and analog codes
// Assumes: everything runs on aclk
// Notes:   codes are fixed so results can be predicted
`timescale 1ns/1ns
`default_nettype none
module pta_far_side
   import pta_pkg::*;
(
   input  wire logic                          aclk,
   input  wire logic [NUM_TRIG-1:0]           fire,
   output logic      [NUM_TRIG-1:0]           trigger_in,
   output logic                               aux_pll_tick,
   output logic                               primary_vco_tick,
   output logic      [NUM_EXT-1:0][RES_W-1:0] ext_analog,
   output logic      [RES_W-1:0]              external_reference_voltage,
   output logic      [RES_W-1:0]              internal_reference_voltage
);
   logic [NUM_TRIG-1:0] fire_q = '0;
   int                  k = 0;
   always @(posedge aclk) begin
      fire_q <= fire;
      k <= k + 1;
   end
   // each source pulses once per request, independent of the others
   assign trigger_in = fire & ~fire_q;
   // unrelated tick rates make the selected source visible
   assign aux_pll_tick = (k % 2) == 0;
   assign primary_vco_tick = (k % 3) == 0;
   for (genvar i = 0; i < NUM_EXT; i++) begin : g_code
      assign ext_analog[i] = RES_W'(64 + 37 * i);
   end
   assign external_reference_voltage = 10'h2aa;
   assign internal_reference_voltage = 10'h155;
endmodule : pta_far_side
`default_nettype wire

/* tb/pta_pair_trigger_adc_test.sv */
// Purpose: self-checking bench of the pair-triggered converter control
// Assumes: AXI4-Lite master tasks, far-side model for triggers and codes
// Notes:   expected codes follow the fixed codes of the far side
`timescale 1ns/1ns
`default_nettype none
module pta_pair_trigger_adc_test
   import pta_pkg::*;
;
   logic aclk = 0, aresetn = 0, device_idle = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0, done_index;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
   logic [NUM_TRIG-1:0] trigger_in, fire = 0;
   logic aux_pll_tick, primary_vco_tick, converter_running, converter_tick, conversion_done;
   logic [NUM_EXT-1:0][RES_W-1:0] ext_analog;
   logic [RES_W-1:0] external_reference_voltage, internal_reference_voltage;
   int n_errors = 0, checks = 0;
   always #5 aclk = ~aclk;
   pta_pair_trigger_adc dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_in, .device_idle, .aux_pll_tick,
      .primary_vco_tick, .ext_analog, .external_reference_voltage,
      .internal_reference_voltage, .converter_running, .converter_tick, .conversion_done,
      .done_index);
   pta_far_side far (.aclk, .fire, .trigger_in, .aux_pll_tick, .primary_vco_tick,
      .ext_analog, .external_reference_voltage, .internal_reference_voltage);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // bready and rready stay high once raised, so back-to-back calls never
   // lower and raise them in one time step; only the watchdog ends a stuck wr or rd wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'h3;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      last_resp = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      last_resp = s_axi_rresp;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk("read", e, d);
   endtask : rchk
   task automatic wait_done(input logic [3:0] idx);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (conversion_done !== 1'b1 && n < 300);
      chk("done", {27'h0, 1'b1, idx}, {27'h0, conversion_done, done_index});
   endtask : wait_done
   function automatic logic [31:0] code(int i);
      if (i == 8) return 32'h2aa;
      if (i == 9) return 32'h155;
      return 32'(64 + 37 * i);
   endfunction : code
   task automatic t_regs;
      rchk(ADDR_CTRL, 32'h3);
      wr(ADDR_CTRL, 32'hffff_ffff);
      rchk(ADDR_CTRL, 32'hb5f7);
      // converter now on: locked fields must survive the clear
      wr(ADDR_CTRL, 32'h3);
      rchk(ADDR_CTRL, 32'h11f7);
      wr(ADDR_CTRL, 32'h3);
      rchk(ADDR_CTRL, 32'h3);
      rchk(8'h08, 32'h0);
      chk("rd resp", 32'(RESP_SLVERR), 32'(last_resp));
      wr(8'h08, 32'h1);
      chk("wr resp", 32'(RESP_SLVERR), 32'(last_resp));
      $display("t_regs done");
   endtask : t_regs
   task automatic t_order;
      wr(ADDR_TRIG, 32'h2);
      wr(ADDR_TRIG + 8'h4, 32'h2);
      wr(ADDR_TRIG + 8'h8, 32'h3);
      wr(ADDR_CTRL, 32'h8003);
      fire <= 14'h3;
      @(posedge aclk);
      fire <= 14'h0;
      for (int i = 0; i < 6; i++) wait_done(4'(i));
      for (int i = 0; i < 6; i++) rchk(ADDR_RESULT + 8'(4 * i), code(i));
      wr(ADDR_CTRL, 32'h9103);
      rchk(ADDR_CTRL, 32'h8003);
      $display("t_order done");
   endtask : t_order
   task automatic t_global;
      int n;
      n = 0;
      wr(ADDR_TRIG + 8'h10, 32'h1);
      wr(ADDR_CTRL, 32'h8403);
      wait_done(4'h8);
      wait_done(4'h9);
      rchk(ADDR_RESULT + 8'h20, 32'h2aa);
      rchk(ADDR_RESULT + 8'h24, 32'h155);
      wr(ADDR_CTRL, 32'h8403);
      repeat (200) begin
         @(posedge aclk);
         if (conversion_done === 1'b1) n++;
      end
      chk("no refire", 32'h0, 32'(n));
      wr(ADDR_CTRL, 32'h8003);
      wr(ADDR_CTRL, 32'h8403);
      wait_done(4'h8);
      wait_done(4'h9);
      $display("t_global done");
   endtask : t_global
   task automatic t_idle;
      wr(ADDR_CTRL, 32'ha003);
      device_idle <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("idle halt", 32'h0, {31'h0, converter_running});
      device_idle <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("idle exit", 32'h1, {31'h0, converter_running});
      wr(ADDR_CTRL, 32'h2003);
      repeat (2) @(posedge aclk);
      chk("power off", 32'h0, {31'h0, converter_running});
      device_idle <= 1'b1;
      wr(ADDR_CTRL, 32'h9003);
      repeat (3) @(posedge aclk);
      chk("idle run", 32'h1, {31'h0, converter_running});
      device_idle <= 1'b0;
      wr(ADDR_CTRL, 32'h3);
      // fractional result_format: the reference code sits left-justified in 16 bits
      wr(ADDR_CTRL, 32'h103);
      rchk(ADDR_RESULT + 8'h20, 32'haa80);
      $display("t_idle done");
   endtask : t_idle
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_order();
      t_global();
      t_idle();
      results();
   end
   // whole run is under a thousand cycles
   initial begin
      #200000;
      n_errors++;
      results();
   end
endmodule : pta_pair_trigger_adc_test
`default_nettype wire
